// ### inc/blis_regs.svh
// Purpose: timing constants and register map of the link init sequencer
// Assumes: 125 MHz clock
// Notes: only BLIS_GTRST_CYC is derived from a time in its own unit; the other counts are raw
`ifndef BLIS_REGS_SVH
`define BLIS_REGS_SVH
`define BLIS_CLK_MHZ 125
`define BLIS_PUP_LOAD 32'h3FFF_FFFF
`define BLIS_GTRST_MS 1000
`define BLIS_GTRST_CYC (`BLIS_GTRST_MS * 1000 * `BLIS_CLK_MHZ)
`define BLIS_CHRST_TX_GT 16'h0010
`define BLIS_CHRST_TX 16'h0020
`define BLIS_CHRST_RX_GT 16'h0040
`define BLIS_CHRST_RX 16'h0080
`define BLIS_CHRST_END 16'h0080
`define BLIS_A_CTRL 2'h0
`define BLIS_A_STAT 2'h1
`define BLIS_C_ENABLE 0
`define BLIS_C_FAULT 1
`define BLIS_C_RESTART 2
`endif

// ### inc/blis_pkg.sv
// Purpose: shared types of the link init sequencer
// Assumes: nothing
// Notes: none
package blis_pkg;
  typedef enum logic [2:0] {
    BLIS_OFF, BLIS_WAIT_GOOD, BLIS_WAIT_READY, BLIS_PUP, BLIS_CHRST, BLIS_RUN
  } blis_state_t;
  typedef logic [3:0] blis_rst_vec_t;
endpackage : blis_pkg

// ### inc/blis_link_if.sv
// Purpose: backplane power handshake and link reset wires between hub and rod
// Assumes: one clock shared by both ends
// Notes: all lines are driven by one end only
`timescale 1ns/100ps
`default_nettype none
interface blis_link_if;
  logic power_on_request;
  logic power_good_ack;
  logic board_ready_to_run;
  logic spare_backplane_reset;
  logic combined_link_reset;
  modport hub (output power_on_request, output combined_link_reset,
    input power_good_ack, input board_ready_to_run, input spare_backplane_reset);
  modport rod (input power_on_request, input combined_link_reset,
    output power_good_ack, output board_ready_to_run, output spare_backplane_reset);
endinterface : blis_link_if
`default_nettype wire

// ### rtl/blis_rod.sv
// Purpose: readout driver end: power-good, ready-to-run, backplane reset, channel timer
// Assumes: configuration done is reported by the user side
// Notes: channel timer starts on the falling edge of the received link reset
`timescale 1ns/100ps
`default_nettype none
`include "blis_regs.svh"
module blis_rod (
  input wire logic clk_i,
  input wire logic rst_b_i,
  blis_link_if.rod link,
  input wire logic config_done_i,
  input wire logic backplane_reset_req_i,
  output logic powered_o,
  output blis_pkg::blis_rst_vec_t chan_rst_o
);
  import blis_pkg::*;
  logic [1:0] pon_s_q, lrst_s_q;
  logic good_q, rdy_q, bpr_q, lrst_prev_q;
  logic [15:0] cnt_q;
  logic run_q;
  blis_rst_vec_t chan_q;
  wire start_w = lrst_prev_q & ~lrst_s_q[1];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pon_s_q <= 2'h0; lrst_s_q <= 2'h0; good_q <= 1'b0; rdy_q <= 1'b0;
      bpr_q <= 1'b0; lrst_prev_q <= 1'b0; cnt_q <= 16'h0000; run_q <= 1'b0;
      chan_q <= 4'hF;
    end else begin
      pon_s_q <= {pon_s_q[0], link.power_on_request};
      lrst_s_q <= {lrst_s_q[0], link.combined_link_reset};
      lrst_prev_q <= lrst_s_q[1];
      good_q <= pon_s_q[1];
      rdy_q <= pon_s_q[1] & good_q & config_done_i;
      bpr_q <= backplane_reset_req_i;
      if (start_w) begin
        run_q <= 1'b1; cnt_q <= 16'h0000; chan_q <= 4'hF;
      end else if (run_q) begin
        cnt_q <= cnt_q + 16'h0001;
        if (cnt_q == `BLIS_CHRST_TX_GT) chan_q[1] <= 1'b0;
        if (cnt_q == `BLIS_CHRST_TX) chan_q[0] <= 1'b0;
        if (cnt_q == `BLIS_CHRST_RX_GT) chan_q[3] <= 1'b0;
        if (cnt_q == `BLIS_CHRST_RX) chan_q[2] <= 1'b0;
        if (cnt_q == `BLIS_CHRST_END) run_q <= 1'b0;
      end
    end
  end
  assign link.power_good_ack = good_q;
  assign link.board_ready_to_run = rdy_q;
  assign link.spare_backplane_reset = bpr_q;
  assign powered_o = good_q;
  assign chan_rst_o = chan_q;
endmodule : blis_rod
`default_nettype wire

// ### rtl/blis_hub.sv
// Purpose: hub end: powers the rod, runs the power-up timer, pulses link reset
// Assumes: software port: addr, wdata, write/read strobes, rdata one cycle later
// Notes: ctrl bit0 enable, bit1 fault restart request, bit2 restart
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "blis_regs.svh"
module blis_hub #(
  parameter logic [31:0] PUP_LOAD = `BLIS_PUP_LOAD,
  parameter logic [31:0] GTRST_CYC = 32'(`BLIS_GTRST_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  blis_link_if.hub link,
  input wire logic config_done_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic pup_timer_o,
  output blis_pkg::blis_rst_vec_t chan_rst_o
);
  import blis_pkg::*;
  blis_state_t st_q, st_d;
  logic [1:0] good_s_q, rdy_s_q, bpr_s_q;
  logic [2:0] ctrl_q;
  logic [31:0] pup_q, gt_q, rdata_q;
  logic pon_q, gtrst_q, pup_out_q, run_q;
  logic [2:0] pup_dly_q;
  logic [15:0] cnt_q;
  blis_rst_vec_t chan_q;
  //////////////////////////////////////////////////////////////////////////////
  wire wr_ctrl_w = wr_i & (addr_i == `BLIS_A_CTRL);
  // fault request and restart are self-clearing command bits
  wire restart_w = (wr_ctrl_w & (wdata_i[`BLIS_C_FAULT] | wdata_i[`BLIS_C_RESTART]))
                   | bpr_s_q[1];
  wire pup_done_w = pup_out_q & (pup_q == 32'h0000_0000);
  // the rod sees the timer fall through two sync flops and an edge flop, so the
  // local start is delayed by the same three stages to start in the same cycle
  wire chan_start_w = pup_dly_q[2] & ~pup_dly_q[1];
  wire [31:0] stat_w = {22'h00_0000, chan_q, pup_out_q, gtrst_q, rdy_s_q[1],
                        good_s_q[1], pon_q, st_q == BLIS_RUN};
  always_comb begin
    st_d = st_q;
    case (st_q)
      BLIS_OFF: if (config_done_i & ctrl_q[`BLIS_C_ENABLE]) st_d = BLIS_WAIT_GOOD;
      BLIS_WAIT_GOOD: if (good_s_q[1]) st_d = BLIS_WAIT_READY;
      BLIS_WAIT_READY: if (rdy_s_q[1]) st_d = BLIS_PUP;
      BLIS_PUP: if (pup_done_w) st_d = BLIS_CHRST;
      BLIS_CHRST: if (!run_q && chan_q == 4'h0) st_d = BLIS_RUN;
      BLIS_RUN: st_d = BLIS_RUN;
      default: st_d = BLIS_OFF;
    endcase
    if (restart_w && st_q != BLIS_OFF) st_d = BLIS_WAIT_GOOD;
    if (!ctrl_q[`BLIS_C_ENABLE]) st_d = BLIS_OFF;
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= BLIS_OFF; good_s_q <= 2'h0; rdy_s_q <= 2'h0; bpr_s_q <= 2'h0;
      ctrl_q <= 3'h0; rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      good_s_q <= {good_s_q[0], link.power_good_ack};
      rdy_s_q <= {rdy_s_q[0], link.board_ready_to_run};
      bpr_s_q <= {bpr_s_q[0], link.spare_backplane_reset};
      if (wr_ctrl_w) ctrl_q <= {1'b0, 1'b0, wdata_i[`BLIS_C_ENABLE]};
      rdata_q <= !rd_i ? 32'h0000_0000 : (addr_i == `BLIS_A_CTRL) ? {29'h0, ctrl_q}
                 : (addr_i == `BLIS_A_STAT) ? stat_w : 32'h0000_0000;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pon_q <= 1'b0; pup_q <= 32'h0000_0000; pup_out_q <= 1'b0; pup_dly_q <= 3'h0;
      gt_q <= 32'h0000_0000; gtrst_q <= 1'b0;
    end else begin
      pon_q <= (st_d != BLIS_OFF);
      pup_dly_q <= {pup_dly_q[1:0], pup_out_q};
      if (st_q == BLIS_WAIT_READY && st_d == BLIS_PUP) begin
        pup_q <= PUP_LOAD; pup_out_q <= 1'b1;
        gt_q <= GTRST_CYC; gtrst_q <= 1'b1;
      end else begin
        if (st_d != BLIS_PUP) pup_out_q <= 1'b0;
        else if (pup_q != 32'h0000_0000) pup_q <= pup_q - 32'h0000_0001;
        if (gt_q != 32'h0000_0000) gt_q <= gt_q - 32'h0000_0001;
        // pulse forced off no later than timer expiry
        if (gt_q == 32'h0000_0001 || st_d != BLIS_PUP) gtrst_q <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 16'h0000; run_q <= 1'b0; chan_q <= 4'hF;
    end else if (chan_start_w) begin
      cnt_q <= 16'h0000; run_q <= 1'b1; chan_q <= 4'hF;
    end else if (run_q) begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == `BLIS_CHRST_TX_GT) chan_q[1] <= 1'b0;
      if (cnt_q == `BLIS_CHRST_TX) chan_q[0] <= 1'b0;
      if (cnt_q == `BLIS_CHRST_RX_GT) chan_q[3] <= 1'b0;
      if (cnt_q == `BLIS_CHRST_RX) chan_q[2] <= 1'b0;
      if (cnt_q == `BLIS_CHRST_END) run_q <= 1'b0;
    end else if (st_q == BLIS_OFF || restart_w) begin
      chan_q <= 4'hF;
    end
  end
  assign link.power_on_request = pon_q;
  // link reset seen by the rod is the power-up timer output; its fall is the common start
  assign link.combined_link_reset = pup_out_q;
  assign rdata_o = rdata_q;
  assign pup_timer_o = pup_out_q;
  assign chan_rst_o = chan_q;
endmodule : blis_hub
`default_nettype wire

// ### dv/blis_link_properties.sv
// Purpose: link handshake and power-up timer checks
// Assumes: one clock, timer never aborted mid-run
// Notes: watches the link wires only
`timescale 1ns/100ps
`default_nettype none
module blis_properties #(
  parameter logic [31:0] PUP_LOAD = 32'h0000_0040
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic power_on_request,
  input wire logic power_good_ack,
  input wire logic board_ready_to_run,
  input wire logic combined_link_reset
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] cnt_q;
  // too long to unroll, so the high time is counted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_q <= 32'h0000_0000;
    else cnt_q <= combined_link_reset ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
  end
  ////////////////////////////////////////
  property p_pon_good; $rose(power_on_request) |-> ##[1:4] power_good_ack; endproperty
  a_pon_good: assert property (p_pon_good) else $error("power good late");
  property p_good_cause; $rose(power_good_ack) |-> $past(power_on_request); endproperty
  a_good_cause: assert property (p_good_cause) else $error("good unasked");
  property p_rdy_good; $rose(board_ready_to_run) |-> power_good_ack; endproperty
  a_rdy_good: assert property (p_rdy_good) else $error("ready before good");
  property p_rdy_tmr;
    $rose(board_ready_to_run) |-> ##[1:4] (combined_link_reset || !power_on_request);
  endproperty
  a_rdy_tmr: assert property (p_rdy_tmr) else $error("timer not started");
  property p_tmr_cause; $rose(combined_link_reset) |-> $past(board_ready_to_run, 2); endproperty
  a_tmr_cause: assert property (p_tmr_cause) else $error("timer before ready");
  property p_tmr_pon; combined_link_reset |-> power_on_request; endproperty
  a_tmr_pon: assert property (p_tmr_pon) else $error("timer unpowered");
  property p_tmr_len; $fell(combined_link_reset) |-> cnt_q == PUP_LOAD + 32'h0000_0001; endproperty
  a_tmr_len: assert property (p_tmr_len) else $error("timer length wrong");
  property p_tmr_gap; $fell(combined_link_reset) |=> !combined_link_reset [*4]; endproperty
  a_tmr_gap: assert property (p_tmr_gap) else $error("timer rearmed");
endmodule : blis_properties
`default_nettype wire

// ### dv/blis_bench.sv
// Purpose: hub and rod joined by the link, driven from the hub port
// Assumes: short timer counts
// Notes: waits and register data drawn from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module blis_bench;
  import blis_pkg::*;
  localparam logic [31:0] PUP = 32'h0000_0040;
  logic clk_i = 1'b0, rst_b_i = 1'b0, hcfg = 1'b0, rcfg = 1'b0, bpr = 1'b0;
  logic wr = 1'b0, rd = 1'b0, pup, powered;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  blis_rst_vec_t hch, rch;
  int errors = 0, n_tests = 0, seed = 32'haf12, th[4], tr[4];
  blis_link_if lk ();
  blis_hub #(.PUP_LOAD(PUP), .GTRST_CYC(32'h0000_0010)) blis_hub_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .link(lk), .config_done_i(hcfg), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pup_timer_o(pup), .chan_rst_o(hch));
  blis_rod blis_rod_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(lk), .config_done_i(rcfg),
    .backplane_reset_req_i(bpr), .powered_o(powered), .chan_rst_o(rch));
  blis_properties #(.PUP_LOAD(PUP)) blis_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .power_on_request(lk.power_on_request), .power_good_ack(lk.power_good_ack),
    .board_ready_to_run(lk.board_ready_to_run), .combined_link_reset(lk.combined_link_reset));
  initial forever #4 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // bounded so a stuck timer ends as a mismatch, not a hang
  task automatic wait_pup(input logic val);
    for (int i = 0; i < 300 && pup !== val; i++) @(posedge clk_i);
    chk(32'(pup), 32'(val));
  endtask : wait_pup
  // release spacing measured from the tx transceiver reset
  function automatic logic [31:0] gap(input int b);
    return b == 0 ? 32'h0000_0010 : b == 2 ? 32'h0000_0070 : b == 3 ? 32'h0000_0030 : 0;
  endfunction : gap
  task automatic wrap_up();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  always @(negedge clk_i) chk(32'(lk.combined_link_reset), 32'(pup));
  initial begin
    #80000;
    errors++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    chk(32'({hch, rch}), 32'h0000_00FF);
    wr_reg(2'h0, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
    chk(32'(lk.power_on_request), 32'h0000_0000);
    hcfg <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(lk.power_on_request), 32'h0000_0001);
    repeat (8 + ($random(seed) & 15)) @(posedge clk_i);
    chk(32'({pup, powered}), 32'h0000_0001);
    rcfg <= 1'b1;
    wait_pup(1'b1);
    rd_reg(2'h1);
    chk(v & 32'h0000_03FE, 32'h0000_03FE);
    repeat (30) @(posedge clk_i);
    rd_reg(2'h1);
    chk(v & 32'h0000_0030, 32'h0000_0020);
    wait_pup(1'b0);
    for (int k = 0; k < 300; k++) begin
      @(negedge clk_i);
      for (int b = 0; b < 4; b++) begin
        if (hch[b] === 1'b1) th[b] = k;
        if (rch[b] === 1'b1) tr[b] = k;
      end
    end
    chk(32'(tr[1] - th[1]), 32'h0000_0000);
    for (int b = 0; b < 4; b++) begin
      chk(32'(th[b] - th[1]), gap(b));
      chk(32'(tr[b] - th[b]), 32'h0000_0000);
    end
    for (int a = 1; a < 4; a++) begin
      wr_reg(2'(a), 32'($random(seed)));
      rd_reg(2'(a));
      chk(v, a == 1 ? 32'h0000_000F : 32'h0000_0000);
    end
    bpr <= 1'b1;
    repeat (4) @(posedge clk_i);
    bpr <= 1'b0;
    wait_pup(1'b1);
    wait_pup(1'b0);
    for (int b = 1; b < 3; b++) begin
      wr_reg(2'h0, 32'h0000_0001 | (32'h0000_0001 << b));
      wait_pup(1'b1);
      wait_pup(1'b0);
    end
    wr_reg(2'h0, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
    chk(32'({lk.power_on_request, powered}), 32'h0000_0000);
    wrap_up();
  end
endmodule : blis_bench
`default_nettype wire
